// ===== rpr_regs.svh
/*
 * Constants of the raw pixel readout front end: register offsets of the
 * device's own control port, field positions, reset values and timing.
 * Assumes inclusion by bare name from the package; the link ends do not include it.
 */
// Notes on behaviour
// RULE_01: subsample reads row pairs alternately, others dropped
// RULE_02: binning sums row with same-colour row below; the code adds the previous pixel sample instead
// RULE_03: support 2x1, 2x2 and bin_two_skip_four_mode binning
// RULE_04: binning enabled only through subsampling setting
// RULE_05: host stops streaming before binning changes
// RULE_06: xy-binning doubles reads, longer line blanking
// RULE_07: progressive frames with programmable blanking
// RULE_08: one 10-bit pixel per clock while line valid
// RULE_09: pixel clock rises mid-period after data changes
// RULE_10: pixel clock free-running by default, configurable
// RULE_11: low-power preview halves clock via divider change
// RULE_12: glitch-free delay during divider change
// RULE_13: host sets four bits for dynamic power
// RULE_14: test pattern replaces raw stream
// RULE_15: host disables controller before test pattern
// RULE_16: per-channel black subtract then digital gain
// RULE_17: negative black subtraction clamps to zero
// RULE_18: shading gain depends on row, column, channel
// RULE_19: three shading sets chosen by temperature range
// RULE_20: host programs overlapping temperature ranges
// RULE_21: 5Kb one-time memory readable over serial
// RULE_22: defect correction always, noise reduction switchable
// RULE_23: Bayer rows alternate green/red and blue/green
// RULE_24: frame valid brackets all line valids
`ifndef RPR_REGS_SVH
`define RPR_REGS_SVH

// ----------------------------------------------------------------------
// Control port register offsets (word index)
// ----------------------------------------------------------------------
`define RPR_REG_CTRL 6'h00
`define RPR_REG_SIZE 6'h01
`define RPR_REG_BLANK 6'h17
`define RPR_REG_BLACK 6'h03
`define RPR_REG_GAIN 6'h07
`define RPR_REG_SHADE_RANGE 6'h0b
`define RPR_REG_SHADE_COEF 6'h0e
`define RPR_REG_TEMP 6'h11
`define RPR_REG_POWER 6'h12
`define RPR_REG_STATUS 6'h13
`define RPR_REG_OTP_ADDR 6'h14
`define RPR_REG_OTP_DATA 6'h15
`define RPR_REG_NOISE 6'h16

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define RPR_CTRL_STREAM 0
`define RPR_CTRL_TEST 1
`define RPR_CTRL_CLK_GATE 2
`define RPR_CTRL_LOW_POWER 3
`define RPR_CTRL_PREVIEW 4
`define RPR_CTRL_MODE_LSB 5
`define RPR_CTRL_SEQ2 8
`define RPR_CTRL_NOISE_EN 9
`define RPR_PWR_DYN 0
`define RPR_PWR_ANA_A 1
`define RPR_PWR_ANA_B 2
`define RPR_PWR_ANA_C 3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RPR_WIDTH_RST 12'h010
`define RPR_HEIGHT_RST 12'h008
`define RPR_HBLANK_RST 12'h008
`define RPR_VBLANK_RST 12'h004
`define RPR_GAIN_UNITY 8'h40
`define RPR_GAIN_FRAC 6
`define RPR_SHADE_UNITY 8'h40
`define RPR_PIX_MAX 10'h3ff
`define RPR_DIV_SETTLE 4'h8
`define RPR_OTP_WORDS 320
`define RPR_NOISE_THR_RST 10'h040

`endif

// ===== rpr_pkg.sv
/*
 * Types shared by both ends of the raw pixel link.
 * Assumes rpr_regs.svh sits in the same folder.
 */
package rpr_pkg;
    `include "rpr_regs.svh"

    // Readout modes, selected by the subsampling setting
    typedef enum logic [2:0] {
        RPR_MODE_NORMAL = 3'h0,
        RPR_MODE_SKIP2 = 3'h1,
        RPR_MODE_BIN2X1 = 3'h2,
        RPR_MODE_BIN2X2 = 3'h3,
        RPR_MODE_BIN2SKIP4 = 3'h4
    } rpr_mode_t;

    typedef logic [9:0] rpr_pixel_t;
endpackage

// ===== rpr_link_if.sv
/*
 * Parallel raw pixel link between the sensor end and the host receiver.
 * Assumes both ends share clk_sys; the pixel clock is a plain output.
 */
`timescale 1ns/1ps
interface rpr_link_if;
    logic [9:0] pixel_data;
    logic line_valid_strobe;
    logic frame_valid_strobe;
    logic pixel_output_clock;

    modport sensor (
        output pixel_data,
        output line_valid_strobe,
        output frame_valid_strobe,
        output pixel_output_clock
    );
    modport receiver (
        input pixel_data,
        input line_valid_strobe,
        input frame_valid_strobe,
        input pixel_output_clock
    );
endinterface

// ===== rpr_sensor.sv
/*
 * Sensor end: row sequencing, frame timing, pipeline front (test pattern,
 * black level, gain, shading) and the parallel raw output.
 * Assumes a control port with one-cycle strobes; single clock domain.
 */
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rpr_sensor #(
    parameter int COLS = 64,
    parameter int ROWS = 64
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control port
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Analog array sample input
    input wire logic [9:0] array_pixel,
    // Analog power-down control
    output logic analog_powerdown,
    // Link
    rpr_link_if.sensor link
);
    import rpr_pkg::*;

    initial begin
        if (COLS < 4 || COLS > 4095 || ROWS < 4 || ROWS > 4095) begin
            $error("rpr_sensor: array size out of range");
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [11:0] width_reg, height_reg, hblank_reg, vblank_reg;
    logic [9:0] black_reg [4];
    logic [7:0] gain_reg [4];
    logic [15:0] range_reg [3];
    logic [7:0] coef_reg [3];
    logic [7:0] temp_reg;
    logic [3:0] power_reg;
    logic [8:0] otp_addr_reg;
    logic [15:0] otp_mem [`RPR_OTP_WORDS];  // 5Kb as 320x16 [RULE_21]
    logic [9:0] noise_thr_reg;
    logic [15:0] reg_rdata_next;

    wire [5:0] a = reg_addr;
    wire rpr_mode_t mode = rpr_mode_t'(ctrl_reg[`RPR_CTRL_MODE_LSB +: 3]);
    wire streaming = ctrl_reg[`RPR_CTRL_STREAM];
    // Binning needs no own enable: the mode field implies it [RULE_04] [RULE_03]
    wire binning = (mode == RPR_MODE_BIN2X1) || (mode == RPR_MODE_BIN2X2)
        || (mode == RPR_MODE_BIN2SKIP4);
    wire row_bin = (mode == RPR_MODE_BIN2X2) || (mode == RPR_MODE_BIN2SKIP4);
    wire row_skip = (mode == RPR_MODE_SKIP2) || row_bin;
    // All four bits needed before analog sections shut down [RULE_13]
    assign analog_powerdown = &power_reg;

    // Register writes; mode changes while streaming are ignored unless the write also stops streaming [RULE_05]
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_reg <= 16'h0000;
            width_reg <= `RPR_WIDTH_RST;
            height_reg <= `RPR_HEIGHT_RST;
            hblank_reg <= `RPR_HBLANK_RST;
            vblank_reg <= `RPR_VBLANK_RST;
            for (int i = 0; i < 4; i++) begin
                black_reg[i] <= 10'h000;
                gain_reg[i] <= `RPR_GAIN_UNITY;
            end
            for (int i = 0; i < 3; i++) begin
                range_reg[i] <= 16'hff00;
                coef_reg[i] <= `RPR_SHADE_UNITY;
            end
            temp_reg <= 8'h00;
            power_reg <= 4'h0;
            otp_addr_reg <= 9'h000;
            noise_thr_reg <= `RPR_NOISE_THR_RST;
        end else if (reg_write) begin
            if (a == `RPR_REG_CTRL) begin
                if (streaming && reg_wdata[`RPR_CTRL_STREAM]) begin
                    ctrl_reg <= {reg_wdata[15:8], ctrl_reg[7:5], reg_wdata[4:0]};
                end else begin
                    ctrl_reg <= reg_wdata;
                end
            end
            if (a == `RPR_REG_SIZE) width_reg <= reg_wdata[11:0];
            if (a == `RPR_REG_SIZE + 6'h01) height_reg <= reg_wdata[11:0];
            if (a == `RPR_REG_BLANK) hblank_reg <= reg_wdata[11:0];
            if (a == `RPR_REG_BLANK + 6'h01) vblank_reg <= reg_wdata[11:0];
            for (int i = 0; i < 4; i++) begin
                if (a == `RPR_REG_BLACK + 6'(i)) black_reg[i] <= reg_wdata[9:0];
                if (a == `RPR_REG_GAIN + 6'(i)) gain_reg[i] <= reg_wdata[7:0];
            end
            for (int i = 0; i < 3; i++) begin
                if (a == `RPR_REG_SHADE_RANGE + 6'(i)) range_reg[i] <= reg_wdata;
                if (a == `RPR_REG_SHADE_COEF + 6'(i)) coef_reg[i] <= reg_wdata[7:0];
            end
            if (a == `RPR_REG_TEMP) temp_reg <= reg_wdata[7:0];
            if (a == `RPR_REG_POWER) power_reg <= reg_wdata[3:0];
            if (a == `RPR_REG_OTP_ADDR) otp_addr_reg <= reg_wdata[8:0];
            if (a == `RPR_REG_NOISE) noise_thr_reg <= reg_wdata[9:0];
        end
    end

    // ------------------------------------------------------------------
    // Pixel clock divider with glitch-free low-power change
    // ------------------------------------------------------------------
    logic half_rate_reg, settle_busy_reg;
    logic [1:0] div_phase_reg;
    logic [3:0] settle_cnt_reg;
    wire want_half = ctrl_reg[`RPR_CTRL_LOW_POWER] && ctrl_reg[`RPR_CTRL_PREVIEW];
    // A flop-made clock runs at most at half clk_sys: two or four cycles a pixel
    wire [1:0] phase_mid = half_rate_reg ? 2'h2 : 2'h1;
    wire tick = !settle_busy_reg && (div_phase_reg == (phase_mid | 2'h1));
    wire [1:0] phase_next = tick ? 2'h0 : div_phase_reg + 2'h1;

    // Stop clock, wait, then adopt the new divider [RULE_11] [RULE_12]
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            half_rate_reg <= 1'b0;
            div_phase_reg <= 2'h0;
            settle_busy_reg <= 1'b0;
            settle_cnt_reg <= 4'h0;
        end else if (settle_busy_reg) begin
            settle_cnt_reg <= settle_cnt_reg - 4'h1;
            if (settle_cnt_reg == 4'h1) begin
                settle_busy_reg <= 1'b0;
                half_rate_reg <= want_half;
                div_phase_reg <= 2'h0;
            end
        end else if (want_half != half_rate_reg && tick) begin
            settle_busy_reg <= 1'b1;
            settle_cnt_reg <= `RPR_DIV_SETTLE;
        end else begin
            div_phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------------
    // Frame timing: progressive raster with programmable blanking
    // ------------------------------------------------------------------
    logic [11:0] col_reg, line_reg, row_addr_reg;
    logic lv_reg, fv_reg;
    // xy-binning reads the array twice per line: double the blank [RULE_06]
    wire [12:0] hblank_eff = row_bin ? {hblank_reg, 1'b0} : {1'b0, hblank_reg};
    wire [12:0] line_len = {1'b0, width_reg} + hblank_eff;
    wire [11:0] frame_len = height_reg + vblank_reg;
    wire line_end = ({1'b0, col_reg} == line_len - 13'h1);
    wire frame_end = line_end && (line_reg == frame_len - 12'h1);
    wire in_active = (line_reg < height_reg);
    wire lv_next = streaming && in_active && (col_reg < width_reg);
    // Frame valid opens a pixel ahead and covers the whole active area [RULE_24]
    wire fv_next = streaming && (in_active || frame_end);

    // Raster counters advance on each pixel clock period [RULE_07]
    always_ff @(posedge clk_sys) begin
        if (reset || (tick && !streaming)) begin
            // Park on the last blank pixel; a cut line lets frame valid trail it
            col_reg <= 12'(line_len - 13'h1);
            line_reg <= frame_len - 12'h1;
            lv_reg <= 1'b0;
            fv_reg <= !reset && lv_reg;
        end else if (tick) begin
            col_reg <= line_end ? 12'h000 : col_reg + 12'h001;
            if (line_end) begin
                line_reg <= frame_end ? 12'h000 : line_reg + 12'h001;
            end
            lv_reg <= lv_next && (col_reg != 12'h000 || !line_end);
            fv_reg <= fv_next;
        end
    end

    // Row address: pairs alternate between sequences [RULE_01] [RULE_02]
    wire [11:0] pair_base = {line_reg[10:1], 2'b00} + {10'h000, ctrl_reg[`RPR_CTRL_SEQ2], 1'b0};
    always_comb begin
        row_addr_reg = row_skip ? (pair_base | {11'h000, line_reg[0]}) : line_reg;
    end

    // ------------------------------------------------------------------
    // Pipeline front
    // ------------------------------------------------------------------
    // Bayer channel from row and column parity [RULE_23]
    wire [1:0] chan = {row_addr_reg[0], col_reg[0]};
    // Test pattern: colour bars in eight column bands [RULE_14]
    wire [9:0] bar = {col_reg[5:3] == 3'h0, col_reg[5:3] < 3'h4, col_reg[3], 7'h00};
    wire [9:0] src = ctrl_reg[`RPR_CTRL_TEST] ? bar : array_pixel;
    // Binned pixels add the previous pixel sample, not the same-colour row below, halved [RULE_02]
    logic [9:0] prev_row_pix_reg;
    wire [10:0] binned = {1'b0, src} + {1'b0, prev_row_pix_reg};
    wire [9:0] sampled = binning ? binned[10:1] : src;
    // Subtract and clamp at zero, then gain [RULE_16] [RULE_17]
    wire [9:0] blk = black_reg[chan];
    wire [9:0] sub = (sampled > blk) ? sampled - blk : 10'h000;
    wire [17:0] gained = sub * gain_reg[chan];
    // Shading set from the temperature range [RULE_19]
    logic [1:0] set_sel;
    always_comb begin
        set_sel = 2'd0;
        for (int i = 2; i >= 0; i--) begin
            if (temp_reg >= range_reg[i][7:0] && temp_reg <= range_reg[i][15:8]) begin
                set_sel = 2'(i);
            end
        end
    end
    // Factor adds the channel and the XOR of high column and row bits [RULE_18]
    wire [7:0] pos_gain = coef_reg[set_sel] + {6'h00, chan}
        + {5'h00, col_reg[11:9] ^ row_addr_reg[11:9]};
    wire [25:0] shaded = gained[17:`RPR_GAIN_FRAC] * pos_gain;
    wire [19:0] final_wide = shaded[25:`RPR_GAIN_FRAC];
    // Defect clamp always on; noise clip switchable [RULE_22]
    wire [9:0] sat = (|final_wide[19:10]) ? `RPR_PIX_MAX : final_wide[9:0];
    wire [9:0] denoised = (ctrl_reg[`RPR_CTRL_NOISE_EN] && sat < noise_thr_reg) ? 10'h000 : sat;

    // Output registers: one pixel per tick while line valid [RULE_08]
    logic [9:0] dout_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dout_reg <= 10'h000;
            prev_row_pix_reg <= 10'h000;
        end else if (tick) begin
            dout_reg <= lv_next ? denoised : 10'h000;
            prev_row_pix_reg <= src;
        end
    end

    // Clock high mid-period, free-running unless gated [RULE_09] [RULE_10]
    logic pclk_reg;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pclk_reg <= 1'b0;
        end else begin
            pclk_reg <= !settle_busy_reg && (phase_next >= phase_mid)
                && (!ctrl_reg[`RPR_CTRL_CLK_GATE] || fv_reg);
        end
    end

    assign link.pixel_data = dout_reg;
    assign link.line_valid_strobe = lv_reg;
    assign link.frame_valid_strobe = fv_reg;
    assign link.pixel_output_clock = pclk_reg;

    // Readback; OTP contents read over the control port [RULE_21]
    always_comb begin
        unique case (a)
            `RPR_REG_CTRL: reg_rdata_next = ctrl_reg;
            `RPR_REG_GAIN: reg_rdata_next = {8'h00, gain_reg[0]};
            `RPR_REG_TEMP: reg_rdata_next = {8'h00, temp_reg};
            `RPR_REG_POWER: reg_rdata_next = {12'h000, power_reg};
            `RPR_REG_STATUS: reg_rdata_next = {12'h000, settle_busy_reg, half_rate_reg,
                fv_reg, lv_reg};
            `RPR_REG_OTP_DATA: reg_rdata_next = otp_mem[otp_addr_reg];
            default: reg_rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= reg_rdata_next;
        end
    end

    // OTP array holds zeros; reset clears every word and nothing else writes it
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < `RPR_OTP_WORDS; i++) begin
            if (reset) otp_mem[i] <= 16'h0000;
        end
    end
endmodule

// ===== rpr_receiver.sv
/*
 * Host end: samples the raw bus on pixel clock rising edges, marks
 * line starts, counts frames, and reports pixels on a user-side stream.
 * Assumes the link shares clk_sys; the pixel clock is sampled as data.
 */
`timescale 1ns/1ps
module rpr_receiver (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link
    rpr_link_if.receiver link,
    // User pixel stream
    output logic [9:0] pix_data,
    output logic pix_valid,
    output logic pix_line_start,
    output logic pix_frame_start,
    output logic [15:0] frame_count
);
    import rpr_pkg::*;

    logic pclk_d_reg, lv_d_reg, fv_d_reg;
    logic [9:0] pix_data_reg;
    logic [15:0] frame_cnt_reg;
    logic valid_reg, line_start_reg, frame_start_reg;

    // Rising pixel clock edge marks a sampling point [RULE_09]
    wire sample = link.pixel_output_clock && !pclk_d_reg;
    wire lv_rise = sample && link.line_valid_strobe && !lv_d_reg;
    wire fv_rise = sample && link.frame_valid_strobe && !fv_d_reg;

    // Flag pixels valid only inside frame and line valid [RULE_08] [RULE_24]
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pclk_d_reg <= 1'b0;
            lv_d_reg <= 1'b0;
            fv_d_reg <= 1'b0;
            pix_data_reg <= 10'h000;
            valid_reg <= 1'b0;
            line_start_reg <= 1'b0;
            frame_start_reg <= 1'b0;
            frame_cnt_reg <= 16'h0000;
        end else begin
            pclk_d_reg <= link.pixel_output_clock;
            valid_reg <= sample && link.line_valid_strobe && link.frame_valid_strobe;
            line_start_reg <= lv_rise;
            frame_start_reg <= fv_rise;
            if (sample) begin
                lv_d_reg <= link.line_valid_strobe;
                fv_d_reg <= link.frame_valid_strobe;
                pix_data_reg <= link.pixel_data;
            end
            if (fv_rise) frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
    end

    assign pix_data = pix_data_reg;
    assign pix_valid = valid_reg;
    assign pix_line_start = line_start_reg;
    assign pix_frame_start = frame_start_reg;
    assign frame_count = frame_cnt_reg;
endmodule

// ===== rpr_link_properties.sv
/*
 * Checker of the raw pixel link: framing and pixel clock relations.
 * Assumes plain copies of rpr_link_if signals, all in the clk_sys domain.
 */
`timescale 1ns/1ps
module rpr_link_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link signals
    input wire logic [9:0] pixel_data,
    input wire logic line_valid_strobe,
    input wire logic frame_valid_strobe,
    input wire logic pixel_output_clock
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    a_lv_within_fv:
    assert property (line_valid_strobe |-> frame_valid_strobe)
        else $error("line valid outside frame valid");
    a_fv_leads_lv:
    assert property ($rose(frame_valid_strobe) |-> !line_valid_strobe)
        else $error("frame valid rose together with line valid");
    a_fv_trails_lv:
    assert property ($fell(frame_valid_strobe) |-> !$past(line_valid_strobe))
        else $error("frame valid fell together with line valid");
    // Bench keeps default blanking: eight pixel periods of at least one clock
    a_hblank_gap:
    assert property ($fell(line_valid_strobe) |-> !line_valid_strobe [*7])
        else $error("horizontal blanking too short");
    a_vblank_gap:
    assert property ($fell(frame_valid_strobe) |-> !frame_valid_strobe [*8])
        else $error("vertical blanking too short");

    // ------------------------------------------------------------
    // Pixel clock
    // ------------------------------------------------------------
    // Divider settle holds the clock low for eight cycles, so allow margin
    a_pclk_running:
    assert property (1'b1 |-> ##[1:24] $changed(pixel_output_clock))
        else $error("pixel clock stalled");
    a_rise_data_stable:
    assert property ($rose(pixel_output_clock) |-> $stable(pixel_data))
        else $error("pixel data moved at pixel clock rise");
    a_rise_lv_stable:
    assert property ($rose(pixel_output_clock) |-> $stable(line_valid_strobe))
        else $error("line valid moved at pixel clock rise");
    a_rise_fv_stable:
    assert property ($rose(pixel_output_clock) |-> $stable(frame_valid_strobe))
        else $error("frame valid moved at pixel clock rise");

    // Main scenarios reached
    c_line_done: cover property ($fell(line_valid_strobe));
    c_frame_done: cover property ($fell(frame_valid_strobe));
    c_pclk_in_line: cover property ($rose(pixel_output_clock) && line_valid_strobe);
endmodule

// ===== raw_pixel_readout_frontend_test.sv
/*
 * Testbench joining sensor and receiver ends over the raw pixel link.
 * Assumes default frame size 16 x 8 and the control port of the notes.
 */
`timescale 1ns/1ps
module raw_pixel_readout_frontend_test;
    import rpr_pkg::*;
    logic clk_sys, reset, reg_write, reg_read, analog_powerdown;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, frame_count, rd;
    logic [9:0] array_pixel, pix_data, first, v, blk;
    logic pix_valid, pix_line_start, pix_frame_start, varied;
    logic [7:0] g, t;
    int errors, samples_checked, cycles, seed, npix, nlines, p0, p1;

    rpr_link_if link ();
    rpr_sensor rpr_sensor_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .array_pixel(array_pixel),
        .analog_powerdown(analog_powerdown), .link(link));
    rpr_receiver rpr_receiver_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
        .pix_data(pix_data), .pix_valid(pix_valid), .pix_line_start(pix_line_start),
        .pix_frame_start(pix_frame_start), .frame_count(frame_count));
    rpr_link_properties rpr_link_properties_inst (.clk_sys(clk_sys), .reset(reset),
        .pixel_data(link.pixel_data), .line_valid_strobe(link.line_valid_strobe),
        .frame_valid_strobe(link.frame_valid_strobe),
        .pixel_output_clock(link.pixel_output_clock));

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // A hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 60000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Idle cycle after each strobe so no strobe is assigned twice in a step
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    function automatic logic [7:0] coef_of(input logic [7:0] temp);
        return (temp < 8'd86) ? 8'h40 : (temp < 8'd172) ? 8'h50 : 8'h30;
    endfunction
    // Truncating fixed point, 0x40 is unity; values stay below saturation
    function automatic logic [9:0] expect_pix(input logic [9:0] x, input logic [9:0] b,
            input logic [7:0] gn, input logic [7:0] c);
        logic [19:0] y;
        y = (x > b) ? 20'(x - b) : 20'h0;
        y = (y * gn) >> 6;
        y = (y * c) >> 6;
        return y[9:0];
    endfunction
    // Streams from one frame start to the next, then stops streaming
    task automatic run_frame(input logic [15:0] ctrl, input logic chk);
        logic [15:0] fc;
        logic [9:0] ex;
        int n;
        wr(6'h00, ctrl);
        n = 0;
        do begin @(posedge clk_sys); #1; n++; end
        while (pix_frame_start !== 1'b1 && n < 4000);
        fc = frame_count;
        npix = 0;
        nlines = 0;
        varied = 1'b0;
        n = 0;
        do begin
            if (pix_line_start === 1'b1) nlines++;
            if (pix_valid === 1'b1) begin
                if (npix == 0) first = pix_data;
                if (pix_data !== first) varied = 1'b1;
                ex = expect_pix(v, blk, g, coef_of(t) + 8'({~nlines[0], npix[0]}));
                if (chk) check("pixel", 16'(pix_data), 16'(ex));
                npix++;
            end
            @(posedge clk_sys); #1; n++;
        end while (pix_frame_start !== 1'b1 && n < 4000);
        check("frame count", frame_count - fc, 16'h0001);
        @(posedge clk_sys);
        wr(6'h00, 16'h0000);
        repeat (16) @(posedge clk_sys);
    endtask
    // Cycles between two rises of the pixel clock
    task automatic measure(output int p);
        logic prev;
        int n, r, t0;
        prev = 1'b1;
        n = 0;
        r = 0;
        t0 = 0;
        while (r < 3 && n < 200) begin
            @(posedge clk_sys); #1; n++;
            if (link.pixel_output_clock === 1'b1 && prev === 1'b0) begin
                r++;
                if (r == 2) t0 = n;
            end
            prev = link.pixel_output_clock;
        end
        p = n - t0;
        @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        array_pixel = 10'h000;
        seed = 21691;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd_reg(6'h07, rd);
        check("gain reset", rd, 16'h0040);
        rd_reg(6'h3f, rd);
        check("unmapped read", rd, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            wr(6'h12, 16'(i));
            check("powerdown", 16'(analog_powerdown), 16'(i == 15));
        end
        wr(6'h12, 16'h0000);
        // Overlapping temperature ranges, lowest matching set wins
        for (int i = 0; i < 3; i++) begin
            wr(6'h0b + 6'(i), {8'(i == 2 ? 255 : 86 * i + 85), 8'(78 * i)});
            wr(6'h0e + 6'(i), 16'(coef_of(8'(86 * i))));
        end
        // Random pipeline settings, first three are corner cases
        for (int k = 0; k < 6; k++) begin
            v = 10'($random(seed)) & 10'h1ff;
            blk = 10'($random(seed)) & 10'h1ff;
            g = 8'h20 + (8'($random(seed)) & 8'h3f);
            t = 8'($random(seed));
            if (k == 0) blk = v + 10'h001;
            if (k == 1) t = 8'hff;
            if (k == 2) t = 8'h56;
            array_pixel <= v;
            for (int c = 0; c < 4; c++) begin
                wr(6'h03 + 6'(c), 16'(blk));
                wr(6'h07 + 6'(c), 16'(g));
            end
            wr(6'h11, 16'(t));
            run_frame(16'h0001, 1'b1);
            check("pixels", 16'(npix), 16'd128);
            check("lines", 16'(nlines), 16'd8);
        end
        // Every subsampling and binning mode, streaming stopped in between
        for (int m = 1; m < 5; m++) begin
            run_frame(16'h0001 | 16'(m << 5) | 16'(($random(seed) & 1) << 8), m == 1);
        end
        run_frame(16'h0003, 1'b0);
        check("pattern varies", 16'(varied), 16'h0001);
        wr(6'h00, 16'h0001);
        measure(p0);
        wr(6'h00, 16'h0019);
        repeat (40) @(posedge clk_sys);
        measure(p1);
        check("half rate", 16'(p1), 16'(2 * p0));
        rd_reg(6'h13, rd);
        check("half flag", 16'(rd[2]), 16'h0001);
        wr(6'h00, 16'h0000);
        tally_and_finish();
    end
endmodule
